// file: cbo_defines.svh
`ifndef CBO_DEFINES_SVH
`define CBO_DEFINES_SVH

// register offsets
`define CBO_ADDR_W            7
`define CBO_OFS_COMMAND       7'h00
`define CBO_OFS_BUS_CTRL      7'h01

// command_launch fields
`define CBO_CMD_POWER_DOWN    7
`define CBO_CMD_RF_OFF        6
`define CBO_CMD_CODE_HI       4
`define CBO_CMD_CODE_LO       0
`define CBO_CMD_RESET         8'h00
`define CBO_CODE_IDLE         5'h00
// busy cycles beyond the command length spent in the start and done pipeline
`define CBO_BUSY_SLACK        2

// bus_access_control fields
`define CBO_BAC_UNLOCK        7
`define CBO_BAC_HOST          6
`define CBO_BAC_MODULE        5
`define CBO_BAC_PORT_HI       3
`define CBO_BAC_PORT_LO       2
`define CBO_BAC_RESET         8'h00

`endif

// file: cbo_pkg.sv
package cbo_pkg;

   typedef enum logic [1:0]
   {
      CBO_PORT_OFF  = 2'h0,
      CBO_PORT_SPI  = 2'h1,
      CBO_PORT_I2CV = 2'h2,
      CBO_PORT_I2C  = 2'h3
   } cbo_port_e;

   typedef enum logic [0:0]
   {
      CBO_IDLE = 1'h0,
      CBO_BUSY = 1'h1
   } cbo_exec_e;

endpackage : cbo_pkg

// file: cbo_done_timer.sv
`timescale 1ns/1ps
// counts a running command down to its completion
module cbo_done_timer #(
   parameter int CNT_W = 8
) (
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] length,
   output logic                  done
);

   logic [CNT_W-1:0] count_reg;
   logic             run_reg;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         count_reg <= '0;
         run_reg   <= 1'b0;
         done      <= 1'b0;
      end
      else if (start)
      begin
         count_reg <= length;
         run_reg   <= 1'b1;
         done      <= 1'b0;
      end
      else if (run_reg && count_reg == '0)
      begin
         run_reg <= 1'b0;
         done    <= 1'b1;
      end
      else
      begin
         count_reg <= run_reg ? count_reg - 1'b1 : count_reg;
         done      <= 1'b0;
      end
   end

endmodule : cbo_done_timer

// file: cbo_command_ctrl.sv
`timescale 1ns/1ps
`include "cbo_defines.svh"

// Operation
// - Power-down bit high enters power-down mode
// - Frontend-off bit powers receiver and transmitter down
// - Bits 4..0 hold the executing command code
// - Command field returns idle after completion
// - Unlock bit allows next write to change
// - Unlock clears itself on next write
// - Host-owner bit gives bus to host
// - Module-owner bit gives bus to module
// - Both owner bits never set together
// - Owner bits set only after unlock
// - Bits 3..2 select secure module port
module cbo_command_ctrl #(
   parameter int EXEC_CYCLES = 16
) (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic [`CBO_ADDR_W-1:0]    reg_addr,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   input  wire logic [7:0]                reg_wdata,
   output logic      [7:0]                reg_rdata,
   output logic                           power_down,
   output logic                           rf_frontend_off,
   output logic      [4:0]                command_code,
   output logic                           command_start,
   output logic                           command_busy,
   output logic                           bus_owned_by_host,
   output logic                           bus_owned_by_secure_module,
   output cbo_pkg::cbo_port_e             secure_module_port_select
);

   logic                power_down_reg;
   logic                rf_off_reg;
   logic [4:0]          code_reg;
   logic                unlock_reg;
   logic                host_reg;
   logic                module_reg;
   cbo_pkg::cbo_port_e  port_reg;
   cbo_pkg::cbo_exec_e  exec_reg;
   logic                start_reg;
   logic                exec_done;
   logic [7:0]          rdata_next;
   logic                wr_cmd;
   logic                wr_bac;
   logic                owner_ok;
   logic [7:0]          busy_len_reg;

   function automatic logic hit(input logic [`CBO_ADDR_W-1:0] a,
                                input logic [`CBO_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign wr_cmd = reg_wr && hit(reg_addr, `CBO_OFS_COMMAND);
   assign wr_bac = reg_wr && hit(reg_addr, `CBO_OFS_BUS_CTRL);

   // owner bits accepted only when unlocked and not both requested
   assign owner_ok = unlock_reg && !(reg_wdata[`CBO_BAC_HOST]
                     && reg_wdata[`CBO_BAC_MODULE]);

   // command register
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         power_down_reg <= 1'b0;
         rf_off_reg     <= 1'b0;
      end
      else if (wr_cmd)
      begin
         power_down_reg <= reg_wdata[`CBO_CMD_POWER_DOWN];
         rf_off_reg     <= reg_wdata[`CBO_CMD_RF_OFF];
      end
   end

   // command code: host write launches, completion returns it to idle
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         code_reg  <= `CBO_CODE_IDLE;
         exec_reg  <= cbo_pkg::CBO_IDLE;
         start_reg <= 1'b0;
      end
      else if (wr_cmd)
      begin
         code_reg  <= reg_wdata[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO];
         start_reg <= (reg_wdata[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO] != `CBO_CODE_IDLE);
         exec_reg  <= (reg_wdata[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO] != `CBO_CODE_IDLE)
                      ? cbo_pkg::CBO_BUSY : cbo_pkg::CBO_IDLE;
      end
      else
      begin
         start_reg <= 1'b0;
         unique case (exec_reg)
            cbo_pkg::CBO_IDLE:
            begin
               exec_reg <= cbo_pkg::CBO_IDLE;
            end
            cbo_pkg::CBO_BUSY:
            begin
               // a done pulse left by a replaced command must not end the new one
               if (exec_done && !start_reg)
               begin
                  code_reg <= `CBO_CODE_IDLE;
                  exec_reg <= cbo_pkg::CBO_IDLE;
               end
            end
         endcase
      end
   end

   cbo_done_timer #(
      .CNT_W  (8)
   ) u_done (
      .mclk   (mclk),
      .reset  (reset),
      .start  (start_reg),
      .length (8'(EXEC_CYCLES)),
      .done   (exec_done)
   );

   // unlock: a bus-control write of 1 while disarmed arms it, any other write disarms it
   always_ff @(posedge mclk)
   begin
      if (reset)
         unlock_reg <= 1'b0;
      else if (reg_wr)
      begin
         if (wr_bac && !unlock_reg)
            unlock_reg <= reg_wdata[`CBO_BAC_UNLOCK];
         else
            unlock_reg <= 1'b0;
      end
   end

   // ownership and port select change only on the unlocked write
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         host_reg   <= 1'b0;
         module_reg <= 1'b0;
         port_reg   <= cbo_pkg::CBO_PORT_OFF;
      end
      else if (wr_bac && unlock_reg)
      begin
         port_reg <= cbo_pkg::cbo_port_e'(reg_wdata[`CBO_BAC_PORT_HI:`CBO_BAC_PORT_LO]);
         if (owner_ok)
         begin
            host_reg   <= reg_wdata[`CBO_BAC_HOST];
            module_reg <= reg_wdata[`CBO_BAC_MODULE];
         end
      end
   end

   // reserved bits read zero so read-modify-write stays harmless
   always_comb
   begin
      rdata_next = 8'h00;
      if (hit(reg_addr, `CBO_OFS_COMMAND))
      begin
         rdata_next[`CBO_CMD_POWER_DOWN] = power_down_reg;
         rdata_next[`CBO_CMD_RF_OFF]     = rf_off_reg;
         rdata_next[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO] = code_reg;
      end
      else if (hit(reg_addr, `CBO_OFS_BUS_CTRL))
      begin
         rdata_next[`CBO_BAC_UNLOCK] = unlock_reg;
         rdata_next[`CBO_BAC_HOST]   = host_reg;
         rdata_next[`CBO_BAC_MODULE] = module_reg;
         rdata_next[`CBO_BAC_PORT_HI:`CBO_BAC_PORT_LO] = port_reg;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_next;
   end

   assign power_down                 = power_down_reg;
   assign rf_frontend_off            = rf_off_reg;
   assign command_code               = code_reg;
   assign command_start              = start_reg;
   assign command_busy               = (exec_reg == cbo_pkg::CBO_BUSY);
   assign bus_owned_by_host          = host_reg;
   assign bus_owned_by_secure_module = module_reg;
   assign secure_module_port_select  = port_reg;

   // measures each busy stretch for the duration check below
   always_ff @(posedge mclk)
   begin
      if (reset || start_reg || !command_busy)
         busy_len_reg <= 8'h00;
      else if (busy_len_reg != 8'hFF)
         busy_len_reg <= busy_len_reg + 8'h01;
   end

   a_owner_exclusive: assert property (@(posedge mclk) disable iff (reset)
      !(host_reg && module_reg))
      else $error("both bus owners set");

   a_owner_locked: assert property (@(posedge mclk) disable iff (reset)
      (!$past(unlock_reg) && ($changed(host_reg) || $changed(module_reg)
      || $changed(port_reg))) |-> $past(reset))
      else $error("owner changed without unlock");

   a_unlock_once: assert property (@(posedge mclk) disable iff (reset)
      (unlock_reg && reg_wr) |=> !unlock_reg)
      else $error("unlock survived a write");

   a_unlock_arm: assert property (@(posedge mclk) disable iff (reset)
      (wr_bac && !unlock_reg && reg_wdata[`CBO_BAC_UNLOCK]) |=> unlock_reg)
      else $error("unlock not armed");

   a_host_grant: assert property (@(posedge mclk) disable iff (reset)
      (wr_bac && unlock_reg && owner_ok) |=> host_reg == $past(reg_wdata[`CBO_BAC_HOST]))
      else $error("host owner not taken");

   a_module_grant: assert property (@(posedge mclk) disable iff (reset)
      (wr_bac && unlock_reg && owner_ok)
      |=> module_reg == $past(reg_wdata[`CBO_BAC_MODULE]))
      else $error("module owner not taken");

   a_both_ignored: assert property (@(posedge mclk) disable iff (reset)
      (wr_bac && reg_wdata[`CBO_BAC_HOST] && reg_wdata[`CBO_BAC_MODULE])
      |=> $stable(host_reg) && $stable(module_reg))
      else $error("double owner request taken");

   a_power_down: assert property (@(posedge mclk) disable iff (reset)
      wr_cmd |=> power_down == $past(reg_wdata[`CBO_CMD_POWER_DOWN]))
      else $error("power-down not applied");

   a_rf_off: assert property (@(posedge mclk) disable iff (reset)
      wr_cmd |=> rf_frontend_off == $past(reg_wdata[`CBO_CMD_RF_OFF]))
      else $error("frontend off not applied");

   a_code_load: assert property (@(posedge mclk) disable iff (reset)
      wr_cmd |=> command_code == $past(reg_wdata[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO]))
      else $error("command code not loaded");

   a_code_done: assert property (@(posedge mclk) disable iff (reset)
      (command_start && !wr_cmd) ##1 (!wr_cmd) [*8] |-> ##[1:20]
      (command_code == `CBO_CODE_IDLE || wr_cmd))
      else $error("command never completed");

   a_port_sel: assert property (@(posedge mclk) disable iff (reset)
      (wr_bac && unlock_reg) |=> secure_module_port_select
      == $past(reg_wdata[`CBO_BAC_PORT_HI:`CBO_BAC_PORT_LO]))
      else $error("port select not applied");

   a_lock_hold: assert property (@(posedge mclk) disable iff (reset)
      (wr_bac && !unlock_reg) |=> $stable(host_reg) && $stable(module_reg) && $stable(port_reg))
      else $error("locked write changed control");

   a_start_pulse: assert property (@(posedge mclk) disable iff (reset)
      (command_start && !wr_cmd) |=> !command_start)
      else $error("start pulse too long");

   a_busy_start: assert property (@(posedge mclk) disable iff (reset)
      (wr_cmd && reg_wdata[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO] != `CBO_CODE_IDLE)
      |=> command_start && command_busy)
      else $error("command not launched");

   a_idle_start: assert property (@(posedge mclk) disable iff (reset)
      (wr_cmd && reg_wdata[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO] == `CBO_CODE_IDLE)
      |=> !command_start && !command_busy)
      else $error("idle code launched a command");

   a_unlock_other: assert property (@(posedge mclk) disable iff (reset)
      (reg_wr && !wr_bac) |=> !unlock_reg)
      else $error("unlock survived another write");

   a_unlock_keep: assert property (@(posedge mclk) disable iff (reset)
      !reg_wr |=> $stable(unlock_reg))
      else $error("unlock moved without a write");

   a_code_read: assert property (@(posedge mclk) disable iff (reset)
      (reg_rd && hit(reg_addr, `CBO_OFS_COMMAND))
      |=> reg_rdata[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO] == $past(command_code))
      else $error("command code read wrong");

   a_owner_read: assert property (@(posedge mclk) disable iff (reset)
      (reg_rd && hit(reg_addr, `CBO_OFS_BUS_CTRL))
      |=> reg_rdata[`CBO_BAC_HOST] == $past(bus_owned_by_host))
      else $error("host owner read wrong");

   a_code_hold: assert property (@(posedge mclk) disable iff (reset)
      (!wr_cmd && !command_busy) |=> $stable(command_code))
      else $error("idle command code moved");

   a_cmd_hold: assert property (@(posedge mclk) disable iff (reset)
      !wr_cmd |=> $stable(power_down) && $stable(rf_frontend_off))
      else $error("power bits moved without a write");

   a_busy_code: assert property (@(posedge mclk) disable iff (reset)
      command_busy |-> command_code != `CBO_CODE_IDLE)
      else $error("busy with idle code");

   a_busy_bound: assert property (@(posedge mclk) disable iff (reset)
      busy_len_reg <= 8'(EXEC_CYCLES + `CBO_BUSY_SLACK))
      else $error("command overran its duration");

endmodule : cbo_command_ctrl

// file: cbo_host_model.sv
`timescale 1ns/1ps
`include "cbo_defines.svh"
// host side of the register port; drives on the falling edge of mclk
module cbo_host_model (
   input  wire logic                   mclk,
   output logic [`CBO_ADDR_W-1:0]      reg_addr,
   output logic                        reg_wr,
   output logic                        reg_rd,
   output logic [7:0]                  reg_wdata,
   input  wire logic [7:0]             reg_rdata
);
   initial
   begin
      reg_addr  = 7'h7F;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'hA5;
   end

   // idle lines show the inverse so a stale value never looks like a fresh write
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr  = a;
      reg_wdata = d & ((a == 7'h00) ? 8'hDF : 8'hEC);
      reg_wr    = 1'b1;
      @(negedge mclk);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~reg_wdata;
   endtask : wr

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge mclk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
   endtask : rd

   task automatic unlock_wr(input logic [7:0] d);
      wr(7'h01, 8'h80);
      wr(7'h01, d);
   endtask : unlock_wr
endmodule : cbo_host_model

// file: command_and_bus_owner_control_bench.sv
`timescale 1ns/1ps
module command_and_bus_owner_control_bench;
   logic               mclk;
   logic               reset;
   logic [6:0]         reg_addr;
   logic               reg_wr;
   logic               reg_rd;
   logic [7:0]         reg_wdata;
   logic [7:0]         reg_rdata;
   logic               power_down;
   logic               rf_frontend_off;
   logic [4:0]         command_code;
   logic               command_start;
   logic               command_busy;
   logic               bus_owned_by_host;
   logic               bus_owned_by_secure_module;
   cbo_pkg::cbo_port_e secure_module_port_select;
   int                 failures;
   int                 checks;
   int                 cycles;
   int                 i;
   int                 k;
   integer             seed;
   logic [7:0]         d;
   logic [7:0]         v;
   logic [7:0]         bac_exp;

   cbo_command_ctrl #(.EXEC_CYCLES(4)) u_cbo_command_ctrl (
      .mclk                       (mclk),
      .reset                      (reset),
      .reg_addr                   (reg_addr),
      .reg_wr                     (reg_wr),
      .reg_rd                     (reg_rd),
      .reg_wdata                  (reg_wdata),
      .reg_rdata                  (reg_rdata),
      .power_down                 (power_down),
      .rf_frontend_off            (rf_frontend_off),
      .command_code               (command_code),
      .command_start              (command_start),
      .command_busy               (command_busy),
      .bus_owned_by_host          (bus_owned_by_host),
      .bus_owned_by_secure_module (bus_owned_by_secure_module),
      .secure_module_port_select  (secure_module_port_select)
   );
   cbo_host_model u_cbo_host_model (
      .mclk      (mclk),
      .reg_addr  (reg_addr),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_wdata (reg_wdata),
      .reg_rdata (reg_rdata)
   );

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // owner bits requested together leave the old owner in place
   function automatic logic [7:0] bac_next(input logic [7:0] old, input logic [7:0] w);
      return {1'b0, (w[6] & w[5]) ? old[6:5] : w[6:5], 1'b0, w[3:2], 2'h0};
   endfunction : bac_next

   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_val

   task automatic chk_bac();
      chk_val({4'h0, bus_owned_by_host, bus_owned_by_secure_module, secure_module_port_select},
              {4'h0, bac_exp[6:5], bac_exp[3:2]});
      u_cbo_host_model.rd(7'h01, v);
      chk_val(v, bac_exp);
   endtask : chk_bac

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         failures++;
         test_done();
      end
   end

   initial
   begin
      reset = 1'b1;
      cycles = 0;
      seed = 32'hB71E5E04;
      bac_exp = 8'h00;
      repeat (6) @(negedge mclk);
      reset = 1'b0;
      chk_val({power_down, rf_frontend_off, command_start, command_busy, bus_owned_by_host,
               bus_owned_by_secure_module, secure_module_port_select}, 8'h00);
      chk_val({3'h0, command_code}, 8'h00);
      chk_bac();
      for (i = 0; i < 6; i++)
      begin
         d = 8'($random(seed)) & 8'hDF;
         if (i == 0)
            d[4:0] = 5'h00;
         u_cbo_host_model.wr(7'h00, d);
         chk_val({7'h0, command_start}, {7'h0, d[4:0] != 5'h00});
         chk_val({7'h0, command_busy}, {7'h0, d[4:0] != 5'h00});
         chk_val({2'h0, power_down, rf_frontend_off, 4'h0}, {2'h0, d[7:6], 4'h0});
         chk_val({3'h0, command_code}, {3'h0, d[4:0]});
         for (k = 0; k < 40 && command_busy !== 1'b0; k++)
            @(negedge mclk);
         chk_val({3'h0, command_code}, 8'h00);
         u_cbo_host_model.rd(7'h00, v);
         chk_val(v, {d[7:6], 6'h00});
      end
      u_cbo_host_model.wr(7'h01, 8'h44);
      chk_bac();
      u_cbo_host_model.wr(7'h01, 8'h80);
      u_cbo_host_model.rd(7'h01, v);
      chk_val(v, 8'h80);
      u_cbo_host_model.wr(7'h01, 8'h44);
      bac_exp = bac_next(bac_exp, 8'h44);
      chk_bac();
      for (i = 0; i < 8; i++)
      begin
         d = 8'($random(seed)) & 8'h6C;
         d[3:2] = i[1:0];
         if (i == 0)
            d = 8'h6C;
         if (i == 1)
            d = 8'h24;
         u_cbo_host_model.unlock_wr(d);
         bac_exp = bac_next(bac_exp, d);
         chk_bac();
      end
      u_cbo_host_model.wr(7'h01, 8'h80);
      u_cbo_host_model.wr(7'h00, 8'h00);
      u_cbo_host_model.wr(7'h01, bac_exp ^ 8'h6C);
      chk_bac();
      u_cbo_host_model.wr(7'h00, 8'hC3);
      u_cbo_host_model.wr(7'h01, 8'h80);
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      bac_exp = 8'h00;
      chk_val({power_down, rf_frontend_off, command_start, command_busy, bus_owned_by_host,
               bus_owned_by_secure_module, secure_module_port_select}, 8'h00);
      chk_val({3'h0, command_code}, 8'h00);
      chk_bac();
      u_cbo_host_model.rd(7'h05, v);
      chk_val(v, 8'h00);
      test_done();
   end
endmodule : command_and_bus_owner_control_bench
